// [logic/uab_autobaud.v]
// Autobaud detecting serial receiver with AXI4-Lite register file
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "uab_defs.vh"

module uab_autobaud #(
	parameter DIV_W = 16
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Serial line and interrupt
	input wire rxd,
	output reg irq
);
	localparam A_IDLE = 3'd0;
	localparam A_WAKE = 3'd1;
	localparam A_START = 3'd2;
	localparam A_COUNT = 3'd3;

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg [4:0] ctrl;
	reg [DIV_W-1:0] divisor;
	reg [7:0] rx_buf;
	reg [`UAB_ST_W-1:0] status;
	reg [`UAB_ST_W-1:0] mask;
	reg [2:0] ab_state;
	reg [2:0] edges;
	reg [11:0] presc;
	reg rxd_q;
	reg wake_seen_low;
	reg [4:0] aw_addr;
	reg aw_have;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_have;

	wire cal_on = ctrl[`UAB_CTL_AUTOBAUD];
	wire rx_rise = rxd & ~rxd_q;
	wire rx_fall = ~rxd & rxd_q;
	wire [3:0] base_shift;
	wire [3:0] cal_shift;
	wire cal_tick;
	wire [7:0] rx_data;
	wire rx_valid;
	wire rx_run;
	wire done_evt;
	wire do_write;
	wire do_read;
	wire rd_rxbuf;
	wire [`UAB_ST_W-1:0] set_bits;

	function [3:0] shift_of;
		input wide;
		input hs;
		begin
			if (wide & hs)
				shift_of = `UAB_SH_FAST;
			else if (wide | hs)
				shift_of = `UAB_SH_MID;
			else
				shift_of = `UAB_SH_SLOW;
		end
	endfunction

	function wr_hit;
		input [4:0] addr;
		input [3:0] reg_off;
		begin
			wr_hit = (addr[4] == 1'b0) && (addr[3:0] == reg_off);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Autobaud clock: base clock divided by 8 gives /512, /128, /32
	assign base_shift = shift_of(ctrl[`UAB_CTL_WIDE], ctrl[`UAB_CTL_HS]);
	assign cal_shift = base_shift + `UAB_CAL_EXTRA; // [RQ9] [RQ10]
	assign cal_tick = (presc & ((12'h001 << cal_shift) - 1'b1)) == 12'h000;

	// Receiver held idle while calibrating
	assign rx_run = ctrl[`UAB_CTL_RXEN] & ~cal_on; // [RQ2] [RQ16]
	assign done_evt = (ab_state == A_COUNT) && rx_rise && (edges == `UAB_EDGES_DONE - 1'b1);

	uab_rx #(
		.DIV_W(DIV_W)
	) u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(rx_run),
		.base_shift(base_shift),
		.divisor(divisor),
		.rxd(rxd),
		.data(rx_data),
		.data_valid(rx_valid)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			rxd_q <= 1'b1;
			presc <= 12'h000;
		end else begin
			rxd_q <= rxd;
			presc <= (ab_state == A_COUNT) ? presc + 1'b1 : 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calibration sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			ab_state <= A_IDLE;
			edges <= 3'd0;
			wake_seen_low <= 1'b0;
		end else begin
			case (ab_state)
			A_IDLE: begin
				edges <= 3'd0;
				wake_seen_low <= 1'b0;
				if (cal_on) // [RQ1]
					ab_state <= ctrl[`UAB_CTL_WAKE] ? A_WAKE : A_START;
			end
			A_WAKE: begin
				// Let the break pass: wait for low then return high
				if (rx_fall)
					wake_seen_low <= 1'b1;
				if (wake_seen_low && rx_rise) // [RQ12]
					ab_state <= A_START;
			end
			A_START: begin
				// Start bit falls, first rising edge begins the count
				if (rx_rise && !rxd_q && wake_seen_low == 1'b0 && edges == 3'd0)
					ab_state <= A_START;
				if (rx_fall)
					edges <= 3'd0;
				if (rx_rise && edges == 3'd0 && !wake_seen_low) begin
					ab_state <= A_COUNT; // [RQ3]
					edges <= 3'd1;
				end
				if (wake_seen_low)
					wake_seen_low <= 1'b0;
			end
			A_COUNT: begin
				if (rx_rise)
					edges <= edges + 1'b1;
				if (done_evt) // [RQ5]
					ab_state <= A_IDLE;
			end
			default: ab_state <= A_IDLE;
			endcase
			if (!cal_on && ab_state != A_COUNT)
				ab_state <= A_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	reg [31:0] next_rdata;
	reg [`UAB_ST_W-1:0] clr_bits;
	reg [`UAB_ST_W-1:0] next_status;
	wire wr_ctrl;
	wire wr_div;
	wire wr_stat;
	wire wr_mask;
	wire cal_load;
	wire cal_step;
	wire ovf_evt;

	function addr_known;
		input [4:0] addr;
		begin
			addr_known = wr_hit(addr, `UAB_REG_CTRL) || wr_hit(addr, `UAB_REG_DIV) ||
				wr_hit(addr, `UAB_REG_RXBUF) || wr_hit(addr, `UAB_REG_STAT) ||
				addr == `UAB_REG_MASK_ADDR;
		end
	endfunction

	assign do_write = aw_have && w_have && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_rxbuf = do_read && wr_hit(s_axi_araddr, `UAB_REG_RXBUF);
	// Byte lane 0 carries every control and status field
	assign wr_ctrl = do_write && wr_hit(aw_addr, `UAB_REG_CTRL) && w_strb[0];
	assign wr_div = do_write && wr_hit(aw_addr, `UAB_REG_DIV);
	assign wr_stat = do_write && wr_hit(aw_addr, `UAB_REG_STAT) && w_strb[0];
	assign wr_mask = do_write && aw_addr == `UAB_REG_MASK_ADDR && w_strb[0];

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data may arrive in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UAB_RESP_OKAY;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_have <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_have <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_known(aw_addr) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel: data registered one cycle after the address is taken
	always @* begin
		next_rdata = 32'h00000000;
		if (wr_hit(s_axi_araddr, `UAB_REG_CTRL))
			next_rdata[4:0] = ctrl;
		else if (wr_hit(s_axi_araddr, `UAB_REG_DIV))
			next_rdata[DIV_W-1:0] = divisor;
		else if (wr_hit(s_axi_araddr, `UAB_REG_RXBUF))
			next_rdata[7:0] = rx_buf;
		else if (wr_hit(s_axi_araddr, `UAB_REG_STAT))
			next_rdata[`UAB_ST_W-1:0] = status;
		else if (s_axi_araddr == `UAB_REG_MASK_ADDR)
			next_rdata[`UAB_ST_W-1:0] = mask;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `UAB_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_known(s_axi_araddr) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
				s_axi_rdata <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `UAB_CTL_RESET;
		end else begin
			if (wr_ctrl)
				ctrl <= w_data[4:0];
			// Hardware clear wins over a software write in the same cycle
			if (done_evt)
				ctrl[`UAB_CTL_AUTOBAUD] <= 1'b0; // [RQ6]
		end
	end

	// Calibration owns the divisor pair as one counter; software writes are dropped while autobaud_enable is set
	assign cal_load = (ab_state == A_START) && rx_rise && (edges == 3'd0) && !wake_seen_low;
	assign cal_step = (ab_state == A_COUNT) && !done_evt && cal_tick;
	assign ovf_evt = cal_step && (&divisor);
	always @(posedge aclk) begin
		if (!aresetn) begin
			divisor <= {DIV_W{1'b0}};
		end else if (cal_load) begin
			divisor <= `UAB_DIV_START; // [RQ13] [RQ8]
		end else if (cal_step) begin
			divisor <= divisor + 1'b1; // [RQ8]
		end else if (wr_div && !cal_on) begin
			if (w_strb[0])
				divisor[7:0] <= w_data[7:0];
			if (w_strb[1])
				divisor[15:8] <= w_data[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status, mask and interrupt; a hardware set wins over any clear
	assign set_bits = {ovf_evt, done_evt, done_evt | rx_valid};
	always @* begin
		clr_bits = {`UAB_ST_W{1'b0}};
		if (wr_stat)
			clr_bits = w_data[`UAB_ST_W-1:0];
		if (rd_rxbuf)
			clr_bits[`UAB_ST_RCV] = 1'b1; // [RQ7]
		next_status = (status & ~clr_bits) | set_bits; // [RQ6]
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			status <= {`UAB_ST_W{1'b0}};
			mask <= {`UAB_ST_W{1'b0}};
			rx_buf <= 8'h00;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			if (wr_mask)
				mask <= w_data[`UAB_ST_W-1:0];
			// Level output, one cycle behind the status it reflects
			irq <= |(status & mask);
			if (rx_valid)
				rx_buf <= rx_data;
		end
	end
endmodule

// [logic/uab_defs.vh]
// Constants for the autobaud detector and its register file
//
// Notes on behaviour
// RQ1: Setting autobaud_enable starts a calibration on the receive line.
// RQ2: Receiver stays idle, no normal reception, while calibrating.
// RQ3: Counting starts at first rising edge after start bit, on autobaud clock.
// RQ4: Remote node sends 55h, five rising edges including the stop edge.
// RQ5: Fifth rising edge stops counting; count left in divisor_high/divisor_low.
// RQ6: On finish hardware clears autobaud_enable and sets receive_flag.
// RQ7: Software reads receive_buffer, discards it; that read clears receive_flag.
// RQ8: Calibration always uses both divisor bytes as one 16-bit counter.
// RQ9: Counter runs at one eighth of the baud generator base clock.
// RQ10: Autobaud clock is sysclk/512, /128 with one select set, /32 with both.
// RQ11: Software checks divisor_high is 00h when only divisor_low is used.
// RQ12: With wake_on_break_enable also set, measure the character after the break.
// RQ13: The autobaud counter starts counting from 1.
// RQ14: Software subtracts one from the pair after calibration.
// RQ15: Software keeps the incoming rate within the measurable range.
// RQ16: Afterwards the receiver runs normally using the measured divisor.
`ifndef UAB_DEFS_VH
`define UAB_DEFS_VH

`define UAB_ADDR_W 4
`define UAB_REG_CTRL 4'h0
`define UAB_REG_DIV 4'h4
`define UAB_REG_RXBUF 4'h8
`define UAB_REG_STAT 4'hC
// Interrupt status is the same register as STAT (sticky, write one to clear)
`define UAB_REG_MASK_ADDR 5'h10

// Control register fields
`define UAB_CTL_AUTOBAUD 0
`define UAB_CTL_WAKE 1
`define UAB_CTL_WIDE 2
`define UAB_CTL_HS 3
`define UAB_CTL_RXEN 4
`define UAB_CTL_RESET 5'h00

// Status bits: 0 receive flag, 1 calibration done, 2 overflow
`define UAB_ST_RCV 0
`define UAB_ST_DONE 1
`define UAB_ST_OVF 2
`define UAB_ST_W 3

// Base divider shifts (base clock = sysclk/64, /16, /4)
`define UAB_SH_SLOW 4'd6
`define UAB_SH_MID 4'd4
`define UAB_SH_FAST 4'd2
// Calibration clock is base / 8
`define UAB_CAL_EXTRA 4'd3
`define UAB_DIV_START 16'h0001
`define UAB_EDGES_DONE 3'd5
`define UAB_RESP_OKAY 2'h0
`define UAB_RESP_SLVERR 2'h2
`define UAB_BITS 4'd8
`define UAB_HALF_BIT 16'h0000

`endif

// [logic/uab_rx.v]
// Plain 8N1 receiver driven by the divisor pair in baud generator fashion
`timescale 1ns/1ns
`include "uab_defs.vh"

module uab_rx #(
	parameter DIV_W = 16
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire run,
	input wire [3:0] base_shift,
	input wire [DIV_W-1:0] divisor,
	input wire rxd,
	// Result
	output reg [7:0] data,
	output reg data_valid
);
	localparam S_IDLE = 2'd0;
	localparam S_START = 2'd1;
	localparam S_DATA = 2'd2;
	localparam S_STOP = 2'd3;

	reg [1:0] state;
	reg [DIV_W+7:0] tick_cnt;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	wire [DIV_W+7:0] bit_len;
	wire bit_end;

	// Bit time = (divisor + 1) base-clock periods
	assign bit_len = ({8'h00, divisor} + 1'b1) << base_shift;
	assign bit_end = (tick_cnt == bit_len - 1'b1);

	always @(posedge aclk) begin
		data_valid <= 1'b0;
		if (!aresetn || !run) begin
			state <= S_IDLE;
			tick_cnt <= {(DIV_W+8){1'b0}};
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			if (!aresetn)
				data <= 8'h00;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			case (state)
			S_IDLE: begin
				tick_cnt <= {(DIV_W+8){1'b0}};
				if (!rxd)
					state <= S_START;
			end
			S_START: begin
				// Sample mid start bit to reject glitches
				if (tick_cnt == (bit_len >> 1)) begin
					tick_cnt <= {(DIV_W+8){1'b0}};
					state <= rxd ? S_IDLE : S_DATA;
					bit_cnt <= 4'h0;
				end
			end
			S_DATA: begin
				if (bit_end) begin
					tick_cnt <= {(DIV_W+8){1'b0}};
					shreg <= {rxd, shreg[7:1]};
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == `UAB_BITS - 1'b1)
						state <= S_STOP;
				end
			end
			S_STOP: begin
				if (bit_end) begin
					state <= S_IDLE;
					data <= shreg;
					data_valid <= 1'b1;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// [test/uab_autobaud_properties.sv]
// Bus handshake and interrupt checks for the autobaud detector
`timescale 1ns/1ns
module uab_chk (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Line and interrupt
	input wire rxd,
	input wire irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_busy: assert property (s_wr |=> !s_axi_awready && !s_axi_wready)
		else $error("write channels not closed");
	a_write_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_ctrl_okay: assert property (s_wr ##0 s_axi_awaddr == 5'h00 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h0)
		else $error("control write refused");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_rd |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	a_read_unmapped: assert property (s_rd ##0 s_axi_araddr == 5'h14 |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// Both the fifth edge and a stop bit leave the line high
	a_irq_on_stop: assert property ($rose(irq) |-> rxd)
		else $error("interrupt raised while line low");
endmodule
bind uab_autobaud uab_chk u_chk (.*);

// [test/uab_node.sv]
// Remote serial node sending an optional break and one character
`timescale 1ns/1ns
module uab_node (
	// Clock
	input wire aclk,
	// Frame request
	input wire go,
	input wire brk,
	input wire [7:0] dat,
	input wire [15:0] bitc,
	// Line
	output reg rxd,
	output reg busy
);
	integer i;
	task tx_bit(input b);
		integer k;
		begin
			rxd <= b;
			for (k = 0; k < bitc; k = k + 1)
				@(posedge aclk);
		end
	endtask
	initial begin
		rxd = 1'b1;
		busy = 1'b0;
	end
	always @(posedge aclk) begin
		if (go) begin
			busy <= 1'b1;
			if (brk) begin
				for (i = 0; i < 13; i = i + 1)
					tx_bit(1'b0);
				tx_bit(1'b1);
			end
			tx_bit(1'b0);
			for (i = 0; i < 8; i = i + 1)
				tx_bit(dat[i]);
			// Extra idle bit so the receiver sees the stop bit whole
			tx_bit(1'b1);
			tx_bit(1'b1);
			busy <= 1'b0;
		end
	end
endmodule

// [test/uab_autobaud_tb.sv]
// Self-checking bench for the autobaud detector
`timescale 1ns/1ns
module uab_autobaud_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] s_axi_awaddr = 5'h00;
	logic s_axi_awvalid = 1'b0;
	wire s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	wire s_axi_wready;
	wire [1:0] s_axi_bresp;
	wire s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [4:0] s_axi_araddr = 5'h00;
	logic s_axi_arvalid = 1'b0;
	wire s_axi_arready;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_rresp;
	wire s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	wire rxd;
	wire irq;
	logic go = 1'b0;
	logic brk = 1'b0;
	logic [7:0] dat = 8'h55;
	logic [15:0] bitc = 16'h0040;
	wire busy;
	int fails = 0;
	int checked = 0;
	logic [31:0] rdv;
	logic [1:0] rr;

	uab_autobaud u_dut (.*);
	uab_node u_node (.aclk(aclk), .go(go), .brk(brk), .dat(dat), .bitc(bitc), .rxd(rxd), .busy(busy));

	initial forever #5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////
	task wr(input [4:0] a, input [31:0] d);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [4:0] a);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (s_axi_rvalid !== 1'b1);
			rdv = s_axi_rdata;
			rr = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			checked++;
			if (g !== e) begin
				fails++;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task report_and_stop;
		begin
			if (fails == 0 && checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Bit time is twice the calibration clock period, so 15 counts plus the start value
	task cal(input [31:0] ctl, input [15:0] b, input bk, input [31:0] msk);
		int n;
		begin
			wr(5'h10, msk);
			bitc <= b;
			brk <= bk;
			dat <= 8'h55;
			wr(5'h00, ctl);
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
			rdv = 32'h0;
			for (n = 0; n < 500 && rdv[1] !== 1'b1; n++) begin
				repeat (64) @(posedge aclk);
				rd(5'h0C);
			end
			chk(rdv[1:0], 32'h3);
			chk(irq, msk != 0);
			rd(5'h00);
			chk(rdv[0], 32'h0);
			rd(5'h04);
			chk(rdv[15:0] > 16'h000F && rdv[15:0] < 16'h0013, 32'h1);
			chk(rdv[15:8], 32'h0);
			rd(5'h08);
			rd(5'h0C);
			chk(rdv[0], 32'h0);
			wr(5'h0C, 32'h7);
			repeat (2) @(posedge aclk);
			chk(irq, 32'h0);
			while (busy) @(posedge aclk);
		end
	endtask
	// Rate slightly slower than the sync speed, which the corrected divisor reproduces, keeps sampling in margin
	task norm;
		begin
			rd(5'h04);
			wr(5'h04, rdv - 32'h1);
			wr(5'h00, 32'h1C);
			dat <= 8'hA5;
			brk <= 1'b0;
			bitc <= 16'h0042;
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
			@(posedge aclk);
			while (busy) @(posedge aclk);
			rd(5'h0C);
			chk(rdv[0], 32'h1);
			rd(5'h08);
			chk(rdv[7:0], 32'hA5);
		end
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(5'h00);
		chk(rdv, 32'h0);
		chk(irq, 32'h0);
		rd(5'h14);
		chk(rr, 32'h2);
		cal(32'h11, 16'h0400, 1'b0, 32'h2);
		cal(32'h15, 16'h0100, 1'b0, 32'h0);
		cal(32'h19, 16'h0100, 1'b0, 32'h2);
		cal(32'h1F, 16'h0040, 1'b1, 32'h0);
		norm;
		report_and_stop;
	end
	initial begin
		repeat (80000) @(posedge aclk);
		fails++;
		report_and_stop;
	end
endmodule
